// ==== design/reset_defaults_and_int_mask.sv ====
// Reset-default register bank with interrupt mask flag registers.
`timescale 1ns/100ps
`default_nettype none
`include "reset_defaults_map.svh"

module reset_defaults_and_int_mask
  import reset_defaults_pkg::*;
#(
  parameter int NUM_REGS = `RD_NUM_REGS,
  parameter int IRQ_W = `RD_IRQ_W
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic OSC_STABLE,
  input wire logic WDT_OPTION_BIT,
  input wire logic WR_EN,
  input wire logic [`RD_SEL_W-1:0] WR_SEL,
  input wire logic [1:0] WR_SIZE,
  input wire logic WR_HIGH,
  input wire logic [3:0] WR_BIT,
  input wire logic [15:0] WR_DATA,
  input wire logic [`RD_SEL_W-1:0] RD_SEL,
  output logic [15:0] RD_DATA,
  input wire logic [IRQ_W-1:0] IRQ_REQ,
  output logic [IRQ_W-1:0] IRQ_SERVICE,
  output logic STALL,
  output logic PC_VALID,
  output logic READY,
  output logic [7:0] SERIAL_ENABLE
);

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values and register widths.
  ////////////////////////////////////////////////////////////////////////////////

  // Default value of each register after reset; depends only on the index, so it is a constant.
  function automatic logic [15:0] reset_value(input int idx);
    logic [15:0] v;
    v = `RD_RST_ZERO;
    if (idx <= `RD_IDX_IRQ_MASK_WORD2) begin
      v = `RD_RST_IRQ_MASK;
    end else if (idx == `RD_IDX_RTC_HOUR || idx == `RD_IDX_ALARM_HOUR) begin
      v = `RD_RST_RTC_HOUR;
    end else if (idx == `RD_IDX_RTC_DAY || idx == `RD_IDX_RTC_MONTH) begin
      v = `RD_RST_RTC_ONE;
    end else if (idx == `RD_IDX_WATCHDOG_ENABLE) begin
      v = `RD_RST_WATCHDOG_ENABLE;
    end else if (idx == `RD_IDX_ADC_PORT_CONFIG) begin
      v = `RD_RST_ADC_PORT_CONFIG;
    end else if (idx >= `RD_IDX_SERIAL_MODE && idx < `RD_IDX_SERIAL_COMM_SETTING) begin
      v = `RD_RST_SERIAL_MODE;
    end else if (idx >= `RD_IDX_SERIAL_COMM_SETTING && idx < `RD_IDX_SERIAL_ENABLE_STATUS) begin
      v = `RD_RST_SERIAL_COMM_SETTING;
    end else if (idx == `RD_IDX_SERIAL_OUTPUT || idx == `RD_IDX_SERIAL_OUTPUT + 1) begin
      v = `RD_RST_SERIAL_OUTPUT;
    end
    return v;
  endfunction

  // Bits that a register actually holds; bits outside read as zero.
  function automatic logic [15:0] width_mask(input int idx);
    logic [15:0] m;
    m = `RD_MASK_BYTE;
    if (idx <= `RD_IDX_IRQ_MASK_WORD2 || idx == `RD_IDX_RTC_SUBCOUNT || idx == `RD_IDX_ADC_RESULT_10BIT) begin
      m = `RD_MASK_WORD;
    end else if (idx >= `RD_IDX_SERIAL_DATA && idx < `RD_IDX_SERIAL_ENABLE_STATUS) begin
      m = `RD_MASK_WORD;
    end else if (idx >= `RD_IDX_SERIAL_ENABLE_STATUS && idx < `RD_IDX_SERIAL_CLOCK_SELECT) begin
      m = `RD_MASK_CHANNELS;
    end else if (idx >= `RD_IDX_SERIAL_CLOCK_SELECT && idx < NUM_REGS) begin
      m = `RD_MASK_WORD;
    end
    return m;
  endfunction

  // Whole-bank reset image, built from constants only.
  function automatic bank_state_t reset_state();
    bank_state_t s;
    s = '0;
    for (int i = 0; i < NUM_REGS; i++) begin
      s.regs[i] = reset_value(i);
    end
    return s;
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // State and the mask gate.
  ////////////////////////////////////////////////////////////////////////////////

  bank_state_t st_reg;
  bank_state_t st_next;
  mask_if mif ();

  logic [15:0] wr_bits;
  logic [15:0] wr_value;
  logic wr_ok;
  logic wr_mapped;
  logic [15:0] merged;
  logic [`RD_SEL_W-1:0] unit_sel;

  // The three mask words travel to the gate as one flat vector, word 0 lowest.
  generate
    for (genvar w = 0; w < 3; w++) begin : g_mask_words
      assign mif.mask[16*w +: 16] = st_reg.regs[w];
    end
  endgenerate

  irq_mask_gate #(
    .IRQ_W(IRQ_W)
  ) u_gate (
    .clk(CLK),
    .rst(RST),
    .ce(CE),
    .mif(mif),
    .irq_req(IRQ_REQ),
    .irq_service(IRQ_SERVICE)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Write lane selection.
  ////////////////////////////////////////////////////////////////////////////////

  // Bit access writes WR_DATA[0] into one bit; byte access picks the low or high half.
  always_comb begin
    wr_bits = 16'h0000;
    wr_value = WR_DATA;
    case (access_size_t'(WR_SIZE))
      ACCESS_BIT: begin
        wr_bits = 16'h0001 << WR_BIT;
        wr_value = {16{WR_DATA[0]}};
      end
      ACCESS_BYTE: begin
        wr_bits = WR_HIGH ? 16'hff00 : 16'h00ff;
        wr_value = {WR_DATA[7:0], WR_DATA[7:0]};
      end
      ACCESS_WORD: begin
        wr_bits = 16'hffff;
        wr_value = WR_DATA;
      end
      default: begin
        wr_bits = 16'h0000;
        wr_value = WR_DATA;
      end
    endcase
  end

  // Writes are refused until the oscillator has settled, so every register keeps its default till then.
  assign wr_mapped = (int'(WR_SEL) < NUM_REGS);
  assign wr_ok = WR_EN & st_reg.ready & wr_mapped;
  assign merged = wr_mapped ? ((st_reg.regs[WR_SEL] & ~wr_bits) | (wr_value & wr_bits)) : 16'h0000;
  assign unit_sel = WR_SEL & 8'h01;

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic.
  ////////////////////////////////////////////////////////////////////////////////

  always_comb begin
    st_next = st_reg;
    st_next.mask_write = 1'b0;

    // First settled cycle after reset: latch the option setting into the watchdog enable value.
    if (!st_reg.ready && OSC_STABLE) begin
      st_next.ready = 1'b1;
      st_next.pc_valid = 1'b1;
      st_next.regs[`RD_IDX_WATCHDOG_ENABLE][`RD_WATCHDOG_ENABLE_REG_OPTION_BIT] = WDT_OPTION_BIT;
    end

    // Triggers never store: start sets enable bits, stop clears them. The enable status is read-only.
    if (wr_ok) begin
      if (WR_SEL == `RD_IDX_SERIAL_START_TRIGGER || WR_SEL == `RD_IDX_SERIAL_START_TRIGGER + 8'h01) begin
        st_next.regs[`RD_IDX_SERIAL_ENABLE_STATUS + unit_sel] =
          st_reg.regs[`RD_IDX_SERIAL_ENABLE_STATUS + unit_sel] | (merged & `RD_MASK_CHANNELS);
      end else if (WR_SEL == `RD_IDX_SERIAL_STOP_TRIGGER || WR_SEL == `RD_IDX_SERIAL_STOP_TRIGGER + 8'h01) begin
        st_next.regs[`RD_IDX_SERIAL_ENABLE_STATUS + unit_sel] =
          st_reg.regs[`RD_IDX_SERIAL_ENABLE_STATUS + unit_sel] & ~(merged & `RD_MASK_CHANNELS);
      end else if (WR_SEL == `RD_IDX_SERIAL_ENABLE_STATUS || WR_SEL == `RD_IDX_SERIAL_ENABLE_STATUS + 8'h01) begin
        st_next.regs[WR_SEL] = st_reg.regs[WR_SEL];
      end else begin
        st_next.regs[WR_SEL] = merged & width_mask(int'(WR_SEL));
      end
      if (WR_SEL <= `RD_IDX_IRQ_MASK_WORD2) begin
        st_next.mask_write = 1'b1;
      end
    end

    // Read data is registered; trigger registers and unmapped selects read zero.
    if (int'(RD_SEL) >= NUM_REGS) begin
      st_next.rd_data = 16'h0000;
    end else if (RD_SEL >= `RD_IDX_SERIAL_START_TRIGGER && RD_SEL < `RD_IDX_SERIAL_CLOCK_SELECT) begin
      st_next.rd_data = 16'h0000;
    end else begin
      st_next.rd_data = st_next.regs[RD_SEL];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // State register.
  ////////////////////////////////////////////////////////////////////////////////

  // Asynchronous reset loads the constant image; the clock enable freezes everything.
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      st_reg <= reset_state();
    end else if (CE) begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs.
  ////////////////////////////////////////////////////////////////////////////////

  // The mask write pulse reaches the gate one cycle after the accepted write.
  assign mif.mask_write = st_reg.mask_write & CE;
  assign STALL = mif.stall;
  assign RD_DATA = st_reg.rd_data;
  assign PC_VALID = st_reg.pc_valid;
  assign READY = st_reg.ready;
  assign SERIAL_ENABLE = {st_reg.regs[`RD_IDX_SERIAL_ENABLE_STATUS + 1][3:0],
                          st_reg.regs[`RD_IDX_SERIAL_ENABLE_STATUS][3:0]};

endmodule

`default_nettype wire

// ==== shared/reset_defaults_map.svh ====
// Register indices, reset values, field positions and timing counts for the reset-default bank.
`ifndef RESET_DEFAULTS_MAP_SVH
`define RESET_DEFAULTS_MAP_SVH

`define RD_NUM_REGS 86
`define RD_SEL_W 8
`define RD_IRQ_W 48

// Interrupt mask words, each a low/high byte pair.
`define RD_IDX_IRQ_MASK_WORD0 8'h00
`define RD_IDX_IRQ_MASK_WORD1 8'h01
`define RD_IDX_IRQ_MASK_WORD2 8'h02

// Real-time counter.
`define RD_IDX_RTC_SUBCOUNT 8'h03
`define RD_IDX_RTC_SECOND 8'h04
`define RD_IDX_RTC_MINUTE 8'h05
`define RD_IDX_RTC_HOUR 8'h06
`define RD_IDX_RTC_DAY 8'h07
`define RD_IDX_RTC_WEEKDAY 8'h08
`define RD_IDX_RTC_MONTH 8'h09
`define RD_IDX_RTC_YEAR 8'h0a
`define RD_IDX_WATCH_ERROR_CORRECTION 8'h0b
`define RD_IDX_ALARM_MINUTE 8'h0c
`define RD_IDX_ALARM_HOUR 8'h0d
`define RD_IDX_ALARM_WEEKDAY 8'h0e
`define RD_IDX_RTC_CONTROL_0 8'h0f
`define RD_IDX_RTC_CONTROL_2 8'h11

// Clock output, watchdog, converters, input switch.
`define RD_IDX_CLKOUT_SELECT_0 8'h12
`define RD_IDX_CLKOUT_SELECT_1 8'h13
`define RD_IDX_WATCHDOG_ENABLE 8'h14
`define RD_IDX_ADC_RESULT_10BIT 8'h15
`define RD_IDX_ADC_PORT_CONFIG 8'h19
`define RD_IDX_DAC_MODE 8'h1c
`define RD_IDX_INPUT_SWITCH_CONTROL 8'h1d

// Serial channel registers: base + channel (0..7, unit*4 + channel).
`define RD_IDX_SERIAL_DATA 8'h20
`define RD_IDX_SERIAL_STATUS 8'h28
`define RD_IDX_SERIAL_FLAG_CLEAR 8'h30
`define RD_IDX_SERIAL_MODE 8'h38
`define RD_IDX_SERIAL_COMM_SETTING 8'h40
// Serial unit registers: base + unit (0..1).
`define RD_IDX_SERIAL_ENABLE_STATUS 8'h48
`define RD_IDX_SERIAL_START_TRIGGER 8'h4a
`define RD_IDX_SERIAL_STOP_TRIGGER 8'h4c
`define RD_IDX_SERIAL_CLOCK_SELECT 8'h4e
`define RD_IDX_SERIAL_OUTPUT 8'h50
`define RD_IDX_SERIAL_OUTPUT_AUX 8'h52
`define RD_IDX_SERIAL_OUTPUT_LEVEL 8'h54

// Reset values.
`define RD_RST_IRQ_MASK 16'hffff
`define RD_RST_ZERO 16'h0000
`define RD_RST_RTC_HOUR 16'h0012
`define RD_RST_RTC_ONE 16'h0001
`define RD_RST_WATCHDOG_ENABLE 16'h001a
`define RD_RST_ADC_PORT_CONFIG 16'h0010
`define RD_RST_SERIAL_MODE 16'h0020
`define RD_RST_SERIAL_COMM_SETTING 16'h0087
`define RD_RST_SERIAL_OUTPUT 16'h0f0f

// Field layout.
`define RD_WATCHDOG_ENABLE_REG_OPTION_BIT 7
`define RD_MASK_BYTE 16'h00ff
`define RD_MASK_WORD 16'hffff
`define RD_MASK_CHANNELS 16'h000f

// Extra execution clocks after a mask register write.
`define RD_MASK_WRITE_EXTRA_CLOCKS 2'd2

`endif

// ==== shared/reset_defaults_pkg.sv ====
// Types shared by the reset-default bank and its interrupt mask gate.
`include "reset_defaults_map.svh"

package reset_defaults_pkg;

  typedef enum logic [1:0] {
    ACCESS_BIT = 2'b00,
    ACCESS_BYTE = 2'b01,
    ACCESS_WORD = 2'b10
  } access_size_t;

  typedef struct packed {
    logic [`RD_NUM_REGS-1:0][15:0] regs;
    logic ready;
    logic pc_valid;
    logic mask_write;
    logic [15:0] rd_data;
  } bank_state_t;

  typedef struct packed {
    logic [1:0] stall_cnt;
    logic [`RD_IRQ_W-1:0] service;
  } gate_state_t;

endpackage

// ==== shared/mask_if.sv ====
// Carrier between the register bank and the interrupt mask gate.
`timescale 1ns/100ps
`default_nettype none
`include "reset_defaults_map.svh"

interface mask_if;
  logic [`RD_IRQ_W-1:0] mask;
  logic mask_write;
  logic stall;

  modport bank (output mask, output mask_write, input stall);
  modport gate (input mask, input mask_write, output stall);
endinterface

`default_nettype wire

// ==== design/irq_mask_gate.sv ====
// Interrupt mask gate: gates requests by mask flags and stretches mask writes by extra clocks.
`timescale 1ns/100ps
`default_nettype none
`include "reset_defaults_map.svh"

module irq_mask_gate
  import reset_defaults_pkg::*;
#(
  parameter int IRQ_W = `RD_IRQ_W
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  mask_if.gate mif,
  input wire logic [IRQ_W-1:0] irq_req,
  output logic [IRQ_W-1:0] irq_service
);

  gate_state_t st_reg;
  gate_state_t st_next;

  // A set mask flag blocks its source, a clear one lets it through, one bit per source.
  always_comb begin
    st_next = st_reg;
    st_next.service = irq_req & ~mif.mask;
    if (mif.mask_write) begin
      st_next.stall_cnt = `RD_MASK_WRITE_EXTRA_CLOCKS;
    end else if (st_reg.stall_cnt != 2'd0) begin
      st_next.stall_cnt = st_reg.stall_cnt - 2'd1;
    end
  end

  // Reset comes up with nothing serviced and no stall pending.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= '0;
    end else if (ce) begin
      st_reg <= st_next;
    end
  end

  // The stall is combinational so the sequencer sees it in the same cycle as the mask write pulse, one cycle after the accepted write.
  assign mif.stall = mif.mask_write | (st_reg.stall_cnt != 2'd0);
  assign irq_service = st_reg.service;

endmodule

`default_nettype wire

// ==== sim/reset_defaults_assertions.sv ====
// Concurrent checks on the ports of the reset-default bank.
`timescale 1ns/100ps
`default_nettype none
`include "reset_defaults_map.svh"

module reset_defaults_assertions
  import reset_defaults_pkg::*;
#(
  parameter int NUM_REGS = `RD_NUM_REGS,
  parameter int IRQ_W = `RD_IRQ_W
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CE,
  input wire logic OSC_STABLE,
  input wire logic WR_EN,
  input wire logic [`RD_SEL_W-1:0] WR_SEL,
  input wire logic [1:0] WR_SIZE,
  input wire logic [15:0] WR_DATA,
  input wire logic [`RD_SEL_W-1:0] RD_SEL,
  input wire logic [15:0] RD_DATA,
  input wire logic [IRQ_W-1:0] IRQ_REQ,
  input wire logic [IRQ_W-1:0] IRQ_SERVICE,
  input wire logic STALL,
  input wire logic PC_VALID,
  input wire logic READY,
  input wire logic [7:0] SERIAL_ENABLE
);
  ////////////////////////////////////////////////////////////////
  // Nibbles kept as nets, since a past value cannot be sliced.
  logic [3:0] en_lo;
  logic [3:0] data_lo;
  logic word_wr;
  assign en_lo = SERIAL_ENABLE[3:0];
  assign data_lo = WR_DATA[3:0];
  assign word_wr = CE && READY && WR_EN && WR_SIZE == 2'b10;

  default clocking cb @(posedge CLK); endclocking
  default disable iff (RST);

  ////////////////////////////////////////////////////////////////
  // The counter becomes valid in the same cycle that writes open.
  a_pc_ready_pair: assert property (PC_VALID == READY)
    else $error("program counter valid and ready disagree");
  a_ready_waits_osc: assert property ($rose(READY) |-> $past(OSC_STABLE) && $past(CE))
    else $error("ready rose before the oscillator settled");
  a_ready_sticks: assert property (READY |=> READY)
    else $error("ready dropped without a reset");
  a_masked_boot: assert property (!READY |-> IRQ_SERVICE == '0)
    else $error("interrupt serviced while all masks are set");
  a_gate_subset: assert property ($past(CE) |-> (IRQ_SERVICE & ~$past(IRQ_REQ)) == '0)
    else $error("interrupt serviced without a request");
  a_stall_cause: assert property ($rose(STALL) |-> $past(WR_EN) && $past(WR_SEL) < 8'h03)
    else $error("stall without a mask write");
  a_stall_holds: assert property ($rose(STALL) |-> STALL[*3])
    else $error("stall shorter than three cycles");
  a_stall_ends: assert property ($rose(STALL) ##0 (CE && !WR_EN)[*3] |=> !STALL)
    else $error("stall longer than three cycles");
  a_start_sets: assert property (word_wr && WR_SEL == 8'h4a |=> en_lo == ($past(en_lo) | $past(data_lo)))
    else $error("start trigger did not set enable bits");
  a_stop_clears: assert property (word_wr && WR_SEL == 8'h4c |=> en_lo == ($past(en_lo) & ~$past(data_lo)))
    else $error("stop trigger did not clear enable bits");
  a_trigger_reads_zero: assert property ($past(CE) && $past(RD_SEL) == 8'h4a |-> RD_DATA == 16'h0000)
    else $error("start trigger read back nonzero");

  // Main scenarios that the bench is expected to reach.
  cover property ($rose(READY));
  cover property ($rose(STALL));
  cover property (|IRQ_SERVICE);
  cover property ($changed(SERIAL_ENABLE));
endmodule

bind reset_defaults_and_int_mask reset_defaults_assertions #(.NUM_REGS(NUM_REGS), .IRQ_W(IRQ_W)) u_chk (
  .CLK(CLK), .RST(RST), .CE(CE), .OSC_STABLE(OSC_STABLE), .WR_EN(WR_EN), .WR_SEL(WR_SEL),
  .WR_SIZE(WR_SIZE), .WR_DATA(WR_DATA), .RD_SEL(RD_SEL), .RD_DATA(RD_DATA), .IRQ_REQ(IRQ_REQ),
  .IRQ_SERVICE(IRQ_SERVICE), .STALL(STALL), .PC_VALID(PC_VALID), .READY(READY),
  .SERIAL_ENABLE(SERIAL_ENABLE)
);

`default_nettype wire

// ==== sim/tb_top.sv ====
// Self-checking bench for the reset-default bank and its mask gate.
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic clk = 1'b0, rst = 1'b1, ce = 1'b1, osc = 1'b0, wdt_opt = 1'b0, wr_en = 1'b0, wr_high = 1'b0;
  logic [7:0] wr_sel = 8'h00, rd_sel = 8'h00;
  logic [1:0] wr_size = 2'b00;
  logic [3:0] wr_bit = 4'h0;
  logic [15:0] wr_data = 16'h0000, rd_data;
  logic [47:0] irq_req = '1, irq_service;
  logic stall, pc_valid, ready;
  logic [7:0] serial_enable;
  int fail_count = 0, n_checks = 0;
  // Index in the top byte, reset value below it.
  logic [23:0] rows [] = '{24'h00ffff, 24'h01ffff, 24'h02ffff, 24'h030000, 24'h040000, 24'h050000,
    24'h060012, 24'h070001, 24'h080000, 24'h090001, 24'h0a0000, 24'h0b0000, 24'h0c0000, 24'h0d0012,
    24'h0e0000, 24'h0f0000, 24'h100000, 24'h110000, 24'h120000, 24'h130000, 24'h14001a, 24'h150000,
    24'h160000, 24'h170000, 24'h180000, 24'h190010, 24'h1a0000, 24'h1b0000, 24'h1c0000, 24'h1d0000,
    24'h200000, 24'h2b0000, 24'h300000, 24'h380020, 24'h3f0020, 24'h400087, 24'h470087, 24'h480000,
    24'h4a0000, 24'h4c0000, 24'h4f0000, 24'h500f0f, 24'h510f0f, 24'h520000, 24'h550000};

  reset_defaults_and_int_mask dut (
    .CLK(clk), .RST(rst), .CE(ce), .OSC_STABLE(osc), .WDT_OPTION_BIT(wdt_opt), .WR_EN(wr_en),
    .WR_SEL(wr_sel), .WR_SIZE(wr_size), .WR_HIGH(wr_high), .WR_BIT(wr_bit), .WR_DATA(wr_data),
    .RD_SEL(rd_sel), .RD_DATA(rd_data), .IRQ_REQ(irq_req), .IRQ_SERVICE(irq_service), .STALL(stall),
    .PC_VALID(pc_valid), .READY(ready), .SERIAL_ENABLE(serial_enable)
  );

  ////////////////////////////////////////////////////////////////
  // Free-running 250 MHz clock.
  initial begin
    forever #2 clk = ~clk;
  end

  task automatic stop_test;
    if (fail_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic chk(input logic [47:0] got, input logic [47:0] exp);
    n_checks++;
    if (got !== exp) begin
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask

  // One write request held for exactly one clock.
  task automatic wr(input logic [7:0] sel, input logic [1:0] sz, input logic hi, input logic [3:0] bp,
                    input logic [15:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    wr_sel <= sel;
    wr_size <= sz;
    wr_high <= hi;
    wr_bit <= bp;
    wr_data <= d;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask

  // Read data is registered, so it is looked at one edge after the index.
  task automatic rd(input logic [7:0] sel, input logic [15:0] exp);
    @(posedge clk);
    rd_sel <= sel;
    @(posedge clk);
    #1;
    chk(48'(rd_data), 48'(exp));
  endtask

  // Called right after a write is taken; counts the stalled cycles that follow.
  task automatic stall_len(input int exp);
    int n;
    n = 0;
    repeat (6) begin
      #1;
      if (stall === 1'b1) n++;
      @(posedge clk);
    end
    chk(48'(n), 48'(exp));
  endtask

  // Reset for six clocks, then a write that must be dropped before settling.
  task automatic boot(input logic opt);
    @(posedge clk);
    rst <= 1'b1;
    osc <= 1'b0;
    wdt_opt <= opt;
    repeat (5) @(posedge clk);
    #1;
    chk(irq_service, 48'h0);
    chk({21'h0, pc_valid, ready, stall, serial_enable, rd_data}, 48'h0);
    @(posedge clk);
    rst <= 1'b0;
    wr(8'h00, 2'b10, 1'b0, 4'h0, 16'h0000);
    #1;
    chk({46'h0, pc_valid, ready}, 48'h0);
    @(posedge clk);
    osc <= 1'b1;
    for (int i = 0; i < 20 && ready !== 1'b1; i++) @(posedge clk);
    #1;
    chk({46'h0, pc_valid, ready}, 48'h3);
  endtask

  ////////////////////////////////////////////////////////////////
  // A hang counts as a failure.
  initial begin
    #200000;
    fail_count++;
    stop_test();
  end

  initial begin
    boot(1'b0);
    foreach (rows[i]) rd(rows[i][23:16], rows[i][15:0]);
    chk(irq_service, 48'h0);
    // Byte, bit, word and high-byte mask writes, each with its own reach.
    wr(8'h00, 2'b01, 1'b0, 4'h0, 16'h0000);
    stall_len(3);
    rd(8'h00, 16'hff00);
    chk(irq_service, 48'h0000_0000_00ff);
    wr(8'h00, 2'b00, 1'b0, 4'h3, 16'h0001);
    stall_len(3);
    wr(8'h01, 2'b10, 1'b0, 4'h0, 16'h00f0);
    wr(8'h02, 2'b01, 1'b1, 4'h0, 16'h000f);
    stall_len(3);
    rd(8'h00, 16'hff08);
    rd(8'h01, 16'h00f0);
    rd(8'h02, 16'h0fff);
    chk(irq_service, 48'hf000_ff0f_00f7);
    // A write elsewhere must not stall and must stick.
    wr(8'h06, 2'b01, 1'b0, 4'h0, 16'h0023);
    stall_len(0);
    rd(8'h06, 16'h0023);
    // Start and stop triggers act on enable status; the start trigger reads zero.
    wr(8'h4a, 2'b10, 1'b0, 4'h0, 16'h0005);
    rd(8'h4a, 16'h0000);
    rd(8'h48, 16'h0005);
    wr(8'h4c, 2'b10, 1'b0, 4'h0, 16'h0001);
    wr(8'h4b, 2'b10, 1'b0, 4'h0, 16'h0003);
    #1;
    chk(48'(serial_enable), 48'h34);
    // With the clock enable low the write is not taken.
    @(posedge clk);
    ce <= 1'b0;
    wr(8'h06, 2'b01, 1'b0, 4'h0, 16'h0055);
    @(posedge clk);
    ce <= 1'b1;
    rd(8'h06, 16'h0023);
    // Second reset in mid-run, option set the other way.
    boot(1'b1);
    rd(8'h14, 16'h009a);
    rd(8'h00, 16'hffff);
    rd(8'h06, 16'h0012);
    chk(irq_service, 48'h0);
    stop_test();
  end
endmodule

`default_nettype wire
